// ===== logic/dsp_pwm_out.sv
// Summary of operation
// - Modes 1 and 5 count up BOTTOM to TOP, then down to BOTTOM.
// - Dual-slope TOP is 0xFF in mode 1, compare A in mode 5.
// - Non-inverting clears on up match, sets on down match; inverse.
// - Counter reverses at TOP and holds TOP for one tick.
// - Dual-slope sets the wrap flag on each arrival at BOTTOM.
// - Compare A at BOTTOM gives steady low, at MAX steady high.
// - Leaving MAX, output takes up-match level at period start.
// - A missed up-count match is made good without a match.
// - One clock; the prescaled tick only enables counter and compare-match updates.
// - Nonzero output mode overrides the pin, except PWM code 01 without toggle; software sets direction.
// - Non-PWM codes: 00 off, 01 toggle, 10 clear, 11 set on match.
// - Fast PWM: 01 toggle if high bit, 10/11 clear/set, BOTTOM opposite.
// - Fast PWM with compare at TOP ignores match, acts at BOTTOM only.
// - Dual-slope: 10 clear up, set down; 11 reverse; 01 toggle if high.
// - Dual-slope with compare at TOP ignores match, acts at TOP only.
// - Toggle-on-match in PWM modes exists for output A only.
// - Dual-slope period is 510 ticks in mode 1, twice compare A in mode 5; prescale 1, 8, 64, 256, 1024.
// - Control A: A mode 7:6, B mode 5:4, zeros 3:2, low mode 1:0.
// - New output mode takes effect at next match, or on force.
// - Mode high bit sits in control B, joined with control A bits.
//
// Design decision made here: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module dsp_pwm_out (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Waveform pins
  output logic            wave_out_a,
  output logic            wave_out_b,
  output logic            wave_ovr_a,
  output logic            wave_ovr_b
);
  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [1:0][1:0]            code;
    logic [1:0]                 wlo;
    logic                       whi;
    logic [2:0]                 cs;
    logic [7:0]                 cnt;
    logic                       down;
    logic [1:0][7:0]            bufv;
    logic [1:0][7:0]            actv;
    logic [1:0][1:0]            acm;
    logic [1:0]                 wv;
    logic [1:0]                 ovr;
    logic [2:0]                 flg;
    logic                       from_max;
    logic [dsp_pkg::PRE_W-1:0]  pre;
    logic [7:0]                 rdat;
  } dsp_state_t;

  dsp_state_t s_r;
  dsp_state_t s_nxt;
  logic       tick;
  logic [2:0] mode;
  logic       dual;
  logic       fast;
  logic       pwm;
  logic [7:0] top;
  logic       at_bot;
  logic       at_top;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic apply(input logic cur, input logic [1:0] c,
                                 input logic tog);
    case (c)
      2'b01:   apply = tog ? ~cur : cur;
      2'b10:   apply = 1'b0;
      2'b11:   apply = 1'b1;
      default: apply = cur;
    endcase
  endfunction

  function automatic logic [1:0] inv(input logic [1:0] c);
    inv = c[1] ? {1'b1, ~c[0]} : c;
  endfunction

  // Free-running divider taps; stopped for select 0 and codes above 5.
  function automatic logic tick_of(input logic [2:0] cs,
                                   input logic [dsp_pkg::PRE_W-1:0] p);
    case (cs)
      3'h1:    tick_of = 1'b1;
      3'h2:    tick_of = &p[2:0];
      3'h3:    tick_of = &p[5:0];
      3'h4:    tick_of = &p[7:0];
      3'h5:    tick_of = &p[9:0];
      default: tick_of = 1'b0;
    endcase
  endfunction

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.pre = s_r.pre + 1'b1;
    tick = tick_of(s_r.cs, s_r.pre);
    mode = {s_r.whi, s_r.wlo};
    dual = (mode == dsp_pkg::MODE_PC_FF) || (mode == dsp_pkg::MODE_PC_A);
    fast = (mode == dsp_pkg::MODE_FP_FF) || (mode == dsp_pkg::MODE_FP_A);
    pwm = dual || fast;
    top = ((mode == dsp_pkg::MODE_PC_A) || (mode == dsp_pkg::MODE_FP_A) ||
           (mode == dsp_pkg::MODE_CTC)) ? s_r.actv[0] : dsp_pkg::CNT_MAX;
    if (tick)
    begin
      if (dual)
      begin
        if (!s_r.down)
        begin
          if (s_r.cnt >= top)
          begin
            s_nxt.down = 1'b1;
            s_nxt.cnt = s_r.cnt - 1'b1;
          end
          else
            s_nxt.cnt = s_r.cnt + 1'b1;
        end
        else if (s_r.cnt == dsp_pkg::CNT_BOTTOM)
        begin
          s_nxt.down = 1'b0;
          s_nxt.cnt = s_r.cnt + 1'b1;
        end
        else
          s_nxt.cnt = s_r.cnt - 1'b1;
      end
      else
      begin
        s_nxt.down = 1'b0;
        s_nxt.cnt = (s_r.cnt == top) ? dsp_pkg::CNT_BOTTOM : s_r.cnt + 1'b1;
      end
    end
    at_bot = tick && s_nxt.cnt == dsp_pkg::CNT_BOTTOM;
    at_top = tick && !s_r.down && s_nxt.cnt == top;
    // Wrap flag; a set in the same cycle as a clear wins.
    if (reg_wr && reg_addr == dsp_pkg::ADR_FLAGS)
      s_nxt.flg = s_r.flg & ~reg_wdata[2:0];
    if ((dual && at_bot && s_r.down) || (fast && at_top) ||
        (!pwm && tick && s_r.cnt == dsp_pkg::CNT_MAX))
      s_nxt.flg[dsp_pkg::FLG_WRAP] = 1'b1;
    // Buffered compare values: TOP in modes 1, 3, 5; BOTTOM in mode 7.
    if ((dual && at_top) || (mode == dsp_pkg::MODE_FP_FF && at_top) ||
        (mode == dsp_pkg::MODE_FP_A && at_bot))
    begin
      s_nxt.actv = s_r.bufv;
      if (dual && s_r.actv[0] == dsp_pkg::CNT_MAX &&
          s_r.bufv[0] != dsp_pkg::CNT_MAX)
        s_nxt.from_max = 1'b1;
    end
    for (int i = 0; i < 2; i++)
    begin
      logic [7:0] ocr;
      logic [1:0] cc;
      logic       tog;
      logic       m;
      logic       frc;
      logic [1:0] eff;
      ocr = s_r.actv[i];
      cc = s_r.code[i];
      tog = (i == 0) && s_r.whi;
      m = tick && s_nxt.cnt == ocr;
      frc = reg_wr && reg_addr == dsp_pkg::ADR_CTRL_B && !pwm &&
            reg_wdata[(i == 0) ? dsp_pkg::FORCE_A : dsp_pkg::FORCE_B];
      eff = cc;
      if (m)
        s_nxt.flg[dsp_pkg::FLG_MA + i] = 1'b1;
      if (!pwm)
      begin
        if (m || frc)
        begin
          s_nxt.acm[i] = cc;
          s_nxt.wv[i] = apply(s_r.wv[i], cc, 1'b1);
        end
      end
      else if (fast)
      begin
        if (m && !(ocr == top && cc[1]))
        begin
          s_nxt.acm[i] = cc;
          s_nxt.wv[i] = apply(s_r.wv[i], cc, tog);
        end
        if (at_bot)
          s_nxt.wv[i] = apply(s_nxt.wv[i], inv(s_r.acm[i]), 1'b0);
      end
      else
      begin
        if (m && !(ocr == top && cc[1]))
        begin
          s_nxt.acm[i] = cc;
          if (s_r.down && ocr != dsp_pkg::CNT_BOTTOM)
            eff = inv(cc);
          s_nxt.wv[i] = apply(s_r.wv[i], eff, tog);
        end
        else if (tick && !s_r.down && s_nxt.cnt > ocr && s_r.acm[i][1])
          s_nxt.wv[i] = apply(s_r.wv[i], s_r.acm[i], 1'b0);
        if (at_top && ocr == top && s_r.acm[i][1])
          s_nxt.wv[i] = apply(s_r.wv[i], inv(s_r.acm[i]), 1'b0);
        if (at_bot && s_r.down && s_r.from_max && s_r.acm[i][1])
          s_nxt.wv[i] = apply(s_r.wv[i], s_r.acm[i], 1'b0);
      end
      s_nxt.ovr[i] = (cc != 2'b00) && !(pwm && cc == 2'b01 && !tog);
    end
    if (dual && at_bot && s_r.down)
      s_nxt.from_max = 1'b0;
    // Register writes; a count write beats the tick in the same cycle.
    if (reg_wr)
    begin
      if (reg_addr == dsp_pkg::ADR_CTRL_A)
      begin
        s_nxt.code[0] = reg_wdata[dsp_pkg::OUTA_LSB +: 2];
        s_nxt.code[1] = reg_wdata[dsp_pkg::OUTB_LSB +: 2];
        s_nxt.wlo = reg_wdata[dsp_pkg::WLO_LSB +: 2];
      end
      else if (reg_addr == dsp_pkg::ADR_CTRL_B)
      begin
        s_nxt.whi = reg_wdata[dsp_pkg::WHI_BIT];
        s_nxt.cs = reg_wdata[dsp_pkg::CS_LSB +: 3];
      end
      else if (reg_addr == dsp_pkg::ADR_COUNT)
        s_nxt.cnt = reg_wdata;
      else if (reg_addr == dsp_pkg::ADR_MATCH_A ||
               reg_addr == dsp_pkg::ADR_MATCH_B)
      begin
        s_nxt.bufv[reg_addr[3]] = reg_wdata;
        if (!pwm)
          s_nxt.actv[reg_addr[3]] = reg_wdata;
      end
    end
    // Read data stands in the cycle after the strobe only.
    s_nxt.rdat = 8'h00;
    if (reg_rd)
    begin
      if (reg_addr == dsp_pkg::ADR_CTRL_A)
        s_nxt.rdat = {s_r.code[0], s_r.code[1], 2'b00, s_r.wlo};
      else if (reg_addr == dsp_pkg::ADR_CTRL_B)
        s_nxt.rdat = {4'h0, s_r.whi, s_r.cs};
      else if (reg_addr == dsp_pkg::ADR_COUNT)
        s_nxt.rdat = s_r.cnt;
      else if (reg_addr == dsp_pkg::ADR_MATCH_A)
        s_nxt.rdat = s_r.bufv[0];
      else if (reg_addr == dsp_pkg::ADR_MATCH_B)
        s_nxt.rdat = s_r.bufv[1];
      else if (reg_addr == dsp_pkg::ADR_FLAGS)
        s_nxt.rdat = {5'h00, s_r.flg};
    end
  end

  // ****************************************************************
  // Registers and outputs
  // ****************************************************************
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign reg_rdata  = s_r.rdat;
  assign wave_out_a = s_r.wv[0];
  assign wave_out_b = s_r.wv[1];
  assign wave_ovr_a = s_r.ovr[0];
  assign wave_ovr_b = s_r.ovr[1];

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_up_count;
    @(posedge clk_sys) disable iff (sys_rst)
    (tick && dual && !s_r.down && s_r.cnt < top && !reg_wr)
      |=> s_r.cnt == $past(s_r.cnt) + 8'h01;
  endproperty
  a_up_count: assert property (p_up_count)
    else $error("dual-slope counter did not count up");
  property p_top_val;
    @(posedge clk_sys) disable iff (sys_rst)
    (tick && dual && !s_r.down && !reg_wr &&
     s_r.cnt == (mode == dsp_pkg::MODE_PC_A ? s_r.actv[0] : dsp_pkg::CNT_MAX))
      |=> s_r.down;
  endproperty
  a_top_val: assert property (p_top_val)
    else $error("counter did not turn at the TOP of its mode");
  property p_reverse;
    @(posedge clk_sys) disable iff (sys_rst)
    (tick && dual && !s_r.down && s_r.cnt == top && top != 8'h00 && !reg_wr)
      |=> s_r.down && s_r.cnt == $past(top) - 8'h01;
  endproperty
  a_reverse: assert property (p_reverse)
    else $error("counter did not turn at TOP");
  property p_wrap;
    @(posedge clk_sys) disable iff (sys_rst)
    (tick && dual && s_r.down && s_r.cnt == 8'h01 && !reg_wr)
      |=> s_r.flg[dsp_pkg::FLG_WRAP] ##1 s_r.flg[dsp_pkg::FLG_WRAP];
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("wrap flag not set at BOTTOM");
  property p_gate;
    @(posedge clk_sys) disable iff (sys_rst)
    (!tick && !reg_wr) |=> $stable(s_r.cnt);
  endproperty
  a_gate: assert property (p_gate)
    else $error("counter moved without a tick");

  property p_nonpwm_clr;
    @(posedge clk_sys) disable iff (sys_rst)
    (!pwm && tick && s_r.code[0] == 2'b10 && s_nxt.cnt == s_r.actv[0])
      |=> !wave_out_a;
  endproperty
  a_nonpwm_clr: assert property (p_nonpwm_clr)
    else $error("clear on match failed");

  property p_pc_up;
    @(posedge clk_sys) disable iff (sys_rst)
    (dual && tick && !s_r.down && s_r.code[0] == 2'b10 &&
     s_nxt.cnt == s_r.actv[0] && s_r.actv[0] != top) |=> !wave_out_a;
  endproperty
  a_pc_up: assert property (p_pc_up)
    else $error("up-count match did not clear output");

  property p_reload;
    @(posedge clk_sys) disable iff (sys_rst)
    (dual && at_top && !reg_wr) |=> s_r.actv[0] == $past(s_r.bufv[0]);
  endproperty
  a_reload: assert property (p_reload)
    else $error("compare copy not loaded at TOP");

  property p_force;
    @(posedge clk_sys) disable iff (sys_rst)
    (!pwm && reg_wr && reg_addr == dsp_pkg::ADR_CTRL_B &&
     reg_wdata[dsp_pkg::FORCE_A] && s_r.code[0] == 2'b11) |=> wave_out_a;
  endproperty
  a_force: assert property (p_force)
    else $error("force strobe did not set output");

  property p_rsvd;
    @(posedge clk_sys) disable iff (sys_rst)
    (reg_rd && reg_addr == dsp_pkg::ADR_CTRL_A) |=> reg_rdata[3:2] == 2'b00;
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved bits read nonzero");

  property p_c_turn;
    @(posedge clk_sys) disable iff (sys_rst) dual && at_top;
  endproperty
  c_turn: cover property (p_c_turn);

  property p_c_fast;
    @(posedge clk_sys) disable iff (sys_rst) fast && at_bot;
  endproperty
  c_fast: cover property (p_c_fast);

  property p_c_from_max;
    @(posedge clk_sys) disable iff (sys_rst) s_r.from_max && at_bot;
  endproperty
  c_from_max: cover property (p_c_from_max);
endmodule
`default_nettype wire

// ===== logic/dsp_pkg.sv
`default_nettype none
package dsp_pkg;
  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] ADR_CTRL_A  = 8'h24;
  localparam logic [7:0] ADR_CTRL_B  = 8'h25;
  localparam logic [7:0] ADR_COUNT   = 8'h26;
  localparam logic [7:0] ADR_MATCH_A = 8'h27;
  localparam logic [7:0] ADR_MATCH_B = 8'h28;
  localparam logic [7:0] ADR_FLAGS   = 8'h29;
  localparam logic [7:0] RST_REG     = 8'h00;
  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int OUTA_LSB  = 6;
  localparam int OUTB_LSB  = 4;
  localparam int WLO_LSB   = 0;
  localparam int FORCE_A   = 7;
  localparam int FORCE_B   = 6;
  localparam int WHI_BIT   = 3;
  localparam int CS_LSB    = 0;
  localparam int FLG_WRAP  = 0;
  localparam int FLG_MA    = 1;
  localparam int FLG_MB    = 2;
  // ****************************************************************
  // Counter values and modes
  // ****************************************************************
  localparam logic [7:0] CNT_MAX    = 8'hff;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [2:0] MODE_PC_FF = 3'h1;
  localparam logic [2:0] MODE_CTC   = 3'h2;
  localparam logic [2:0] MODE_FP_FF = 3'h3;
  localparam logic [2:0] MODE_PC_A  = 3'h5;
  localparam logic [2:0] MODE_FP_A  = 3'h7;
  // ****************************************************************
  // Prescaler: divide by 1, 8, 64, 256 or 1024
  // ****************************************************************
  localparam int PRE_W = 10;
endpackage
`default_nettype wire

// ===== tb/dsp_pwm_out_tb.sv
`timescale 1ns/100ps
`default_nettype none
module dsp_pwm_out_tb;
  // ****************************************************************
  // Signals
  // ****************************************************************
  typedef struct packed
  {
    logic [7:0] ctrl;
    logic [7:0] rdback;
    logic       out;
    logic       ovr;
  } dsp_row_t;
  logic       clk_sys;
  logic       sys_rst;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       wave_out_a;
  logic       wave_out_b;
  logic       wave_ovr_a;
  logic       wave_ovr_b;
  int         fails;
  int         samples_checked;
  int         hi;
  int         rs;
  logic [7:0] d;
  // Force rows: code, readback with reserved bits zero, level, override.
  dsp_row_t   rows [6] = '{
    '{8'hc0, 8'hc0, 1'b1, 1'b1}, '{8'h40, 8'h40, 1'b0, 1'b1},
    '{8'h80, 8'h80, 1'b0, 1'b1}, '{8'hcc, 8'hc0, 1'b1, 1'b1},
    '{8'h4f, 8'h43, 1'b1, 1'b0}, '{8'h40, 8'h40, 1'b0, 1'b1}};
  dsp_pwm_out dut (
    .clk_sys    (clk_sys),
    .sys_rst    (sys_rst),
    .reg_addr   (reg_addr),
    .reg_wdata  (reg_wdata),
    .reg_wr     (reg_wr),
    .reg_rd     (reg_rd),
    .reg_rdata  (reg_rdata),
    .wave_out_a (wave_out_a),
    .wave_out_b (wave_out_b),
    .wave_ovr_a (wave_ovr_a),
    .wave_ovr_b (wave_ovr_b)
  );
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic stop_test();
    if (fails == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [7:0] exp,
                     input logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic chki(input string name, input int exp, input int got);
    samples_checked++;
    if (got != exp)
    begin
      fails++;
      $display("wrong value %s expected %0d seen %0d", name, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1 v = reg_rdata;
  endtask
  // Settles for n cycles, then counts high cycles and rising edges.
  task automatic win(input logic sel, input int n, output int h,
                     output int r);
    logic prev;
    logic cur;
    h = 0;
    r = 0;
    repeat (n) @(posedge clk_sys);
    #1 prev = sel ? wave_out_b : wave_out_a;
    repeat (n)
    begin
      @(posedge clk_sys);
      #1 cur = sel ? wave_out_b : wave_out_a;
      if ($isunknown(cur))
        h -= 1000;
      if (cur === 1'b1)
        h++;
      if (cur === 1'b1 && prev === 1'b0)
        r++;
      prev = cur;
    end
  endtask
  // ****************************************************************
  // Clock, reset and watchdog
  // ****************************************************************
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // A hung run still ends in the closing report.
  initial
  begin
    #9000000;
    fails++;
    stop_test();
  end
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    fails = 0;
    samples_checked = 0;
    sys_rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    #1 chk("outputs at reset", 8'h00,
           {4'h0, wave_out_a, wave_out_b, wave_ovr_a, wave_ovr_b});
    rd(dsp_pkg::ADR_CTRL_A, d);
    chk("control a reset", 8'h00, d);
    // Codes applied through the force strobe, counter stopped; row 0x4f is fast PWM, where force is ignored.
    foreach (rows[i])
    begin
      wr(dsp_pkg::ADR_CTRL_A, rows[i].ctrl);
      rd(dsp_pkg::ADR_CTRL_A, d);
      chk("control a readback", rows[i].rdback, d);
      wr(dsp_pkg::ADR_CTRL_B, 8'h80);
      @(posedge clk_sys);
      #1 chk("forced level a", {7'h0, rows[i].out}, {7'h0, wave_out_a});
      chk("override a", {7'h0, rows[i].ovr}, {7'h0, wave_ovr_a});
    end
    wr(dsp_pkg::ADR_CTRL_A, 8'h00);
    // The override register follows the code register one edge later.
    @(posedge clk_sys);
    #1 chk("override a off", 8'h00, {7'h0, wave_ovr_a});
    wr(8'h30, 8'h5a);
    rd(8'h30, d);
    chk("unmapped read", 8'h00, d);
    wr(dsp_pkg::ADR_COUNT, 8'h05);
    repeat (20) @(posedge clk_sys);
    rd(dsp_pkg::ADR_COUNT, d);
    chk("count with tick off", 8'h05, d);
    // Dual-slope over 0xff, match at 2.
    wr(dsp_pkg::ADR_MATCH_A, 8'h02);
    wr(dsp_pkg::ADR_CTRL_A, 8'h81);
    wr(dsp_pkg::ADR_CTRL_B, 8'h01);
    win(1'b0, 520, hi, rs);
    chki("non-inverted high time", 4, hi);
    chki("rises per 510", 1, rs);
    wr(dsp_pkg::ADR_CTRL_A, 8'hc1);
    win(1'b0, 520, hi, rs);
    chki("inverted high time", 516, hi);
    chki("inverted rises", 1, rs);
    wr(dsp_pkg::ADR_CTRL_A, 8'h81);
    wr(dsp_pkg::ADR_CTRL_B, 8'h02);
    win(1'b0, 4080, hi, rs);
    chki("high time at divide 8", 32, hi);
    chki("rises at divide 8", 1, rs);
    wr(dsp_pkg::ADR_CTRL_B, 8'h01);
    wr(dsp_pkg::ADR_MATCH_A, 8'h00);
    win(1'b0, 510, hi, rs);
    chki("match at bottom", 0, hi);
    // A new compare only takes hold at TOP, so a spare period is allowed.
    wr(dsp_pkg::ADR_MATCH_A, 8'hff);
    repeat (510) @(posedge clk_sys);
    win(1'b0, 510, hi, rs);
    chki("match at max", 510, hi);
    wr(dsp_pkg::ADR_MATCH_A, 8'h80);
    repeat (510) @(posedge clk_sys);
    win(1'b0, 510, hi, rs);
    chki("leaving max", 256, hi);
    // Fast PWM over 0xff: set at BOTTOM, clear at the match at 0x40.
    wr(dsp_pkg::ADR_MATCH_A, 8'h40);
    wr(dsp_pkg::ADR_CTRL_A, 8'h83);
    repeat (256) @(posedge clk_sys);
    win(1'b0, 256, hi, rs);
    chki("fast high time", 64, hi);
    chki("fast rises", 1, rs);
    // Clear on compare with compare 3: toggle, then clear on match.
    wr(dsp_pkg::ADR_CTRL_A, 8'h42);
    wr(dsp_pkg::ADR_MATCH_A, 8'h03);
    wr(dsp_pkg::ADR_COUNT, 8'h00);
    win(1'b0, 8, hi, rs);
    chki("toggle high time", 4, hi);
    chki("toggle rises", 1, rs);
    wr(dsp_pkg::ADR_CTRL_A, 8'h82);
    win(1'b0, 8, hi, rs);
    chki("clear on match", 0, hi);
    // Dual-slope with TOP taken from match a, output b at 4.
    wr(dsp_pkg::ADR_CTRL_B, 8'h00);
    wr(dsp_pkg::ADR_CTRL_A, 8'h00);
    wr(dsp_pkg::ADR_COUNT, 8'h00);
    wr(dsp_pkg::ADR_MATCH_A, 8'h10);
    wr(dsp_pkg::ADR_MATCH_B, 8'h04);
    wr(dsp_pkg::ADR_CTRL_A, 8'h21);
    wr(dsp_pkg::ADR_CTRL_B, 8'h09);
    win(1'b1, 32, hi, rs);
    chki("period from match a", 8, hi);
    chki("rises per 32", 1, rs);
    chk("overrides", 8'h01, {6'h0, wave_ovr_a, wave_ovr_b});
    rd(dsp_pkg::ADR_FLAGS, d);
    chk("wrap flag", 8'h01, d & 8'h01);
    wr(dsp_pkg::ADR_CTRL_B, 8'h08);
    wr(dsp_pkg::ADR_FLAGS, 8'h07);
    rd(dsp_pkg::ADR_FLAGS, d);
    chk("flags cleared", 8'h00, d);
    stop_test();
  end
endmodule
`default_nettype wire
